// ===== logic/qfd_pkg.sv
package qfd_pkg;

  localparam logic [7:0] OFF_FILTER_CTRL = 8'h00;
  localparam logic [7:0] OFF_IFACE_CTRL = 8'h04;
  localparam logic [7:0] OFF_POSITION = 8'h08;

  localparam int FILT_EN_BIT = 7;
  localparam int FILT_DIV_LSB = 4;
  localparam int IF_DIR_OE_BIT = 6;
  localparam int IF_SWAP_BIT = 7;
  localparam int IF_MODE_LSB = 8;
  localparam int IF_DIR_BIT = 11;

  localparam logic FILT_EN_RST = 1'b0;
  localparam logic [2:0] FILT_DIV_RST = 3'h0;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [15:0] POSITION_RST = 16'h0000;
  localparam logic DIR_RST = 1'b0;

  localparam int FILT_SAMPLES = 3;
  localparam int NUM_CH = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    E_NONE = 3'b000,
    E_A_RISE = 3'b001,
    E_A_FALL = 3'b010,
    E_B_RISE = 3'b011,
    E_B_FALL = 3'b100
  } qfd_edge_t;

  // Divisor minus one for each select code
  function automatic logic [7:0] qfd_div_max(input logic [2:0] sel);
    logic [7:0] r;
    r = 8'h00;
    case (sel)
      3'h0: r = 8'h00;
      3'h1: r = 8'h01;
      3'h2: r = 8'h03;
      3'h3: r = 8'h0F;
      3'h4: r = 8'h1F;
      3'h5: r = 8'h3F;
      3'h6: r = 8'h7F;
      default: r = 8'hFF;
    endcase
    return r;
  endfunction : qfd_div_max

endpackage : qfd_pkg

// ===== logic/qfd_glitch_filter.sv
`timescale 1ns/1ns
module qfd_glitch_filter
  import qfd_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic [NUM_CH-1:0] raw,
  output logic [NUM_CH-1:0] filt
);

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      logic [FILT_SAMPLES-1:0] samp;
      wire all_high = &samp;
      wire all_low = ~|samp;
      always_ff @(posedge clk) begin
        if (srst) begin
          samp <= '0;
          filt[i] <= 1'b0;
        end else if (tick) begin
          samp <= {samp[FILT_SAMPLES-2:0], raw[i]};
          if (all_high)
            filt[i] <= 1'b1;
          else if (all_low)
            filt[i] <= 1'b0;
        end
      end

      a_filt_three: assert property (@(posedge clk) disable iff (srst)
        $changed(filt[i]) |-> $past(tick) && ($past(samp) == {FILT_SAMPLES{filt[i]}}))
        else $error("Filtered level changed without three equal samples");
    end
  endgenerate

endmodule : qfd_glitch_filter

// ===== logic/qfd_decoder_top.sv
`timescale 1ns/1ns
// Contract
// - Filtered output changes only after three equal samples on filter clock edges.
// - Spikes between filter edges ignored; pulses under two filter periods rejected.
// - Filter clock is the system clock divided by a programmable divisor.
// - Filter enable bit 7 of filter control applies filter to A, B, index.
// - Bits 6:4 of filter control pick one divisor for all three channels.
// - Decoder works on conditioned phase and index signals, giving pulses and direction; the index is only conditioned and passed out as index_cond.
// - Counting active only when counter mode field bit 10 is set.
// - In x4 mode every edge of A or B alone gives one count pulse; A and B edges in the same cycle give none.
// - Mode 10x counts only A edges; B still decides direction.
// - Leading transitions set direction up and increment.
// - Lagging transitions clear direction and decrement.
// - Edge after opposite edge of same phase toggles direction.
// - Direction drives its pin when output enable set and pin set as output.
// - Live direction readable at bit 11 of interface control.
// - Swap clear: A feeds decoder A, B feeds decoder B.
// - Swap set: phases exchanged so A leading B decrements.
// - Position is 16-bit up/down, one step per count pulse.
// - Writing the counter mode field leaves the position unchanged.
module qfd_decoder_top
  import qfd_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  input wire logic index_in,
  input wire logic pin_direction_ctrl,
  output logic dir_pin_out,
  output logic dir_pin_oe,
  output logic count_pulse,
  output logic count_direction,
  output logic index_cond,
  output logic [15:0] position_count
);

  logic filter_enable;
  logic [2:0] filter_clk_div_sel;
  logic [2:0] counter_mode_sel;
  logic phase_swap_sel;
  logic direction_pin_out_en;
  logic [7:0] div_cnt;
  logic [NUM_CH-1:0] filt;
  logic prev_a;
  logic prev_b;
  qfd_edge_t last_edge;
  qfd_edge_t cur_edge;
  logic next_dir;

  // Register bus decode
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  wire wr_filt = wr_go && (s_axi_awaddr[7:2] == OFF_FILTER_CTRL[7:2]);
  wire wr_iface = wr_go && (s_axi_awaddr[7:2] == OFF_IFACE_CTRL[7:2]);
  wire wr_pos = wr_go && (s_axi_awaddr[7:2] == OFF_POSITION[7:2]);
  wire wr_hit = wr_filt | wr_iface | wr_pos;
  wire rd_filt = s_axi_araddr[7:2] == OFF_FILTER_CTRL[7:2];
  wire rd_iface = s_axi_araddr[7:2] == OFF_IFACE_CTRL[7:2];
  wire rd_pos = s_axi_araddr[7:2] == OFF_POSITION[7:2];
  wire rd_hit = rd_filt | rd_iface | rd_pos;
  wire [31:0] filt_word = {24'h0000_00, filter_enable, filter_clk_div_sel, 4'h0};
  wire [31:0] iface_word = {20'h0000_0, count_direction, counter_mode_sel,
                            phase_swap_sel, direction_pin_out_en, 6'h00};
  wire [31:0] rd_word = rd_filt ? filt_word :
                        rd_iface ? iface_word :
                        rd_pos ? {16'h0000, position_count} : 32'h0000_0000;

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (srst) begin
      filter_enable <= FILT_EN_RST;
      filter_clk_div_sel <= FILT_DIV_RST;
    end else if (wr_filt && s_axi_wstrb[0]) begin
      filter_enable <= s_axi_wdata[FILT_EN_BIT];
      filter_clk_div_sel <= s_axi_wdata[FILT_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_swap_sel <= 1'b0;
      direction_pin_out_en <= 1'b0;
      counter_mode_sel <= MODE_RST;
    end else if (wr_iface) begin
      if (s_axi_wstrb[0]) begin
        phase_swap_sel <= s_axi_wdata[IF_SWAP_BIT];
        direction_pin_out_en <= s_axi_wdata[IF_DIR_OE_BIT];
      end
      if (s_axi_wstrb[1])
        counter_mode_sel <= s_axi_wdata[IF_MODE_LSB +: 3];
    end
  end

  // Filter clock divider
  wire div_wrap = div_cnt >= qfd_div_max(filter_clk_div_sel);
  wire filt_tick = filter_enable & div_wrap;
  always_ff @(posedge clk) begin
    if (srst || !filter_enable || div_wrap)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  qfd_glitch_filter u_filter (
    .clk(clk),
    .srst(srst),
    .tick(filt_tick),
    .raw({index_in, phase_b_in, phase_a_in}),
    .filt(filt)
  );

  // Conditioned inputs, swap
  wire cond_a = filter_enable ? filt[0] : phase_a_in;
  wire cond_b = filter_enable ? filt[1] : phase_b_in;
  assign index_cond = filter_enable ? filt[2] : index_in;
  wire dec_a = phase_swap_sel ? cond_b : cond_a;
  wire dec_b = phase_swap_sel ? cond_a : cond_b;

  // Edge detection
  wire a_edge = dec_a ^ prev_a;
  wire b_edge = dec_b ^ prev_b;
  wire one_edge = a_edge ^ b_edge;
  wire active = counter_mode_sel[2];
  wire x2_mode = counter_mode_sel[2:1] == 2'b10;
  wire pulse_now = one_edge & active & (a_edge | ~x2_mode);

  always_comb begin
    cur_edge = E_NONE;
    if (a_edge && !b_edge)
      cur_edge = dec_a ? E_A_RISE : E_A_FALL;
    else if (b_edge && !a_edge)
      cur_edge = dec_b ? E_B_RISE : E_B_FALL;
  end

  // Lead/lag test
  always_comb begin
    next_dir = count_direction;
    case (cur_edge)
      E_A_RISE: begin
        if (last_edge == E_A_FALL)
          next_dir = ~count_direction;
        else
          next_dir = (last_edge == E_B_FALL) || (last_edge == E_NONE && !dec_b);
      end
      E_A_FALL: begin
        if (last_edge == E_A_RISE)
          next_dir = ~count_direction;
        else
          next_dir = (last_edge == E_B_RISE) || (last_edge == E_NONE && dec_b);
      end
      E_B_RISE: begin
        if (last_edge == E_B_FALL)
          next_dir = ~count_direction;
        else
          next_dir = (last_edge == E_A_RISE) || (last_edge == E_NONE && dec_a);
      end
      E_B_FALL: begin
        if (last_edge == E_B_RISE)
          next_dir = ~count_direction;
        else
          next_dir = (last_edge == E_A_FALL) || (last_edge == E_NONE && !dec_a);
      end
      default: next_dir = count_direction;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      last_edge <= E_NONE;
      count_direction <= DIR_RST;
      count_pulse <= 1'b0;
    end else begin
      prev_a <= dec_a;
      prev_b <= dec_b;
      count_pulse <= pulse_now;
      if (one_edge) begin
        last_edge <= cur_edge;
        count_direction <= next_dir;
      end else if (a_edge) begin
        last_edge <= E_NONE;
      end
    end
  end

  // Position counter
  always_ff @(posedge clk) begin
    if (srst)
      position_count <= POSITION_RST;
    else if (wr_pos && (s_axi_wstrb[1:0] != 2'b00))
      position_count <= {s_axi_wstrb[1] ? s_axi_wdata[15:8] : position_count[15:8],
                         s_axi_wstrb[0] ? s_axi_wdata[7:0] : position_count[7:0]};
    else if (count_pulse)
      position_count <= count_direction ? position_count + 16'h0001 : position_count - 16'h0001;
  end

  // Direction pin
  assign dir_pin_oe = direction_pin_out_en & ~pin_direction_ctrl;
  assign dir_pin_out = count_direction;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_a_rise_after_b_fall;
    (last_edge == E_B_FALL) ##0 (cur_edge == E_A_RISE);
  endsequence

  sequence s_b_rise_after_a_rise;
    (last_edge == E_A_RISE) ##0 (cur_edge == E_B_RISE);
  endsequence

  a_idle_no_count: assert property (!active |=> !count_pulse)
    else $error("Count pulse while position mode off");
  a_x2_a_only: assert property (x2_mode && !a_edge |=> !count_pulse)
    else $error("Count pulse on B edge in x2 mode");
  a_x4_b_counts: assert property (counter_mode_sel[2:1] == 2'b11 && b_edge && !a_edge |=> count_pulse)
    else $error("B edge missed in x4 mode");
  a_lead_sets_up: assert property (s_a_rise_after_b_fall |=> count_direction)
    else $error("Leading transition did not set direction");
  a_lag_clears: assert property (last_edge == E_B_RISE && cur_edge == E_A_RISE |=> !count_direction)
    else $error("Lagging transition did not clear direction");
  a_reversal_toggle: assert property (last_edge == E_A_FALL && cur_edge == E_A_RISE
    |=> count_direction != $past(count_direction))
    else $error("Reversal did not toggle direction");
  a_pos_step: assert property (count_pulse && !wr_pos |=>
    position_count == ($past(count_direction) ? $past(position_count) + 16'h0001 : $past(position_count) - 16'h0001))
    else $error("Position did not step by one");
  a_mode_keeps_pos: assert property (wr_iface && !count_pulse |=> $stable(position_count))
    else $error("Mode write disturbed position");
  a_swap_route: assert property (phase_swap_sel |-> dec_a == cond_b && dec_b == cond_a)
    else $error("Swap not applied at decoder");
  a_bypass_raw: assert property (!filter_enable |-> cond_a == phase_a_in && index_cond == index_in)
    else $error("Raw input not used with filter off");
  a_dir_pin: assert property (direction_pin_out_en && !pin_direction_ctrl |-> dir_pin_oe && dir_pin_out == count_direction)
    else $error("Direction pin not driven");
  a_dir_readback: assert property (rd_go && rd_iface |=> s_axi_rdata[IF_DIR_BIT] == $past(count_direction))
    else $error("Direction readback wrong");
  a_lead_b_rise: assert property (s_b_rise_after_a_rise |=> count_direction)
    else $error("B rise after A rise did not set direction");
  a_lag_b_fall: assert property (last_edge == E_A_RISE && cur_edge == E_B_FALL |=> !count_direction)
    else $error("B fall after A rise did not clear direction");
  a_a_edge_counts: assert property (active && a_edge && !b_edge |=> count_pulse)
    else $error("A edge missed in position mode");
  a_dir_hold: assert property (!one_edge |=> $stable(count_direction))
    else $error("Direction changed without an edge");
  a_tick_spacing: assert property (filt_tick && filter_clk_div_sel != 3'h0
    |=> !filt_tick || filter_clk_div_sel == 3'h0)
    else $error("Filter tick faster than divisor");
  a_swap_clear: assert property (!phase_swap_sel |-> dec_a == cond_a && dec_b == cond_b)
    else $error("Phases exchanged with swap clear");

endmodule : qfd_decoder_top

// ===== tb/qfd_encoder_model.sv
`timescale 1ns/1ns
module qfd_encoder_model (
  input wire logic clk,
  output logic phase_a,
  output logic phase_b,
  output logic index_out
);
  logic [1:0] st = 2'h0;
  logic [2:0] gl = 3'h0;
  // Gray order 00,10,11,01: A leads B going forward
  assign phase_a = st[0] ^ st[1] ^ gl[0];
  assign phase_b = st[1] ^ gl[1];
  assign index_out = gl[2];
  task automatic step(input logic fwd, input int hold);
    st <= fwd ? st + 2'h1 : st - 2'h1;
    repeat (hold) @(posedge clk);
  endtask : step
  // Inverts one line for n cycles, then settles
  task automatic glitch(input int ch, input int n);
    gl[ch] <= 1'b1;
    repeat (n) @(posedge clk);
    gl[ch] <= 1'b0;
    repeat (16) @(posedge clk);
  endtask : glitch
endmodule : qfd_encoder_model

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import qfd_pkg::*;
  logic clk = 0, srst = 1, pdc = 1;
  logic [7:0] awa = 0, ara = 0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [31:0] wd = 0;
  wire logic awr, wr, bv, arr, rv, pa, pb, pi, dpo, doe, cp, cd, ic;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd;
  wire logic [15:0] pos;
  int errors = 0, compares = 0, pulses = 0, p, hi;
  always #50 clk = ~clk;
  always @(posedge clk) if (cp === 1'b1) pulses <= pulses + 1;
  qfd_encoder_model u_enc (.clk(clk), .phase_a(pa), .phase_b(pb), .index_out(pi));
  qfd_decoder_top u_dut (.clk(clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .phase_a_in(pa),
    .phase_b_in(pb), .index_in(pi), .pin_direction_ctrl(pdc), .dir_pin_out(dpo),
    .dir_pin_oe(doe), .count_pulse(cp), .count_direction(cd), .index_cond(ic),
    .position_count(pos));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    do begin @(posedge clk); end while (!(awr === 1 && wr === 1));
    awv <= 0;
    wv <= 0;
    bry <= 1;
    do begin @(posedge clk); end while (bv !== 1);
    chk(br, er);
    bry <= 0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    ara <= a;
    arv <= 1;
    do begin @(posedge clk); end while (arr !== 1);
    arv <= 0;
    rry <= 1;
    do begin @(posedge clk); end while (rv !== 1);
    chk(rd, e);
    chk(rr, er);
    rry <= 0;
  endtask : rd_chk
  task automatic watch(input int n);
    hi = 0;
    repeat (n) begin @(posedge clk); hi += (ic === 1'b1); end
  endtask : watch
  task automatic t_reset;
    rd_chk(8'h00, 0, RESP_OKAY);
    rd_chk(8'h04, 0, RESP_OKAY);
    rd_chk(8'h08, 0, RESP_OKAY);
    rd_chk(8'h0C, 0, RESP_SLVERR);
    wr_reg(8'h0C, 32'h0000_00FF, RESP_SLVERR);
  endtask : t_reset
  task automatic t_x4;
    wr_reg(8'h04, 32'h0000_0600);
    wr_reg(8'h08, 32'h0000_FFFE);
    p = pulses;
    repeat (3) u_enc.step(1, 4);
    cyc(3);
    chk(pos, 16'h0001);
    chk(pulses - p, 3);
    chk(cd, 1);
    rd_chk(8'h04, 32'h0000_0E00, RESP_OKAY);
  endtask : t_x4
  task automatic t_rev;
    repeat (2) u_enc.step(0, 4);
    cyc(3);
    chk(cd, 0);
    chk(pos, 16'hFFFF);
    rd_chk(8'h04, 32'h0000_0600, RESP_OKAY);
  endtask : t_rev
  task automatic t_x2;
    wr_reg(8'h04, 32'h0000_0400);
    chk(pos, 16'hFFFF);
    p = pulses;
    repeat (4) u_enc.step(1, 4);
    cyc(3);
    chk(pulses - p, 2);
    chk(pos, 16'h0001);
  endtask : t_x2
  task automatic t_swap;
    wr_reg(8'h04, 32'h0000_0680);
    repeat (4) u_enc.step(1, 4);
    cyc(3);
    chk(pos, 16'hFFFD);
    chk(cd, 0);
  endtask : t_swap
  task automatic t_idle;
    wr_reg(8'h04, 32'h0000_0000);
    p = pulses;
    repeat (4) u_enc.step(1, 4);
    cyc(3);
    chk(pulses - p, 0);
    chk(pos, 16'hFFFD);
  endtask : t_idle
  task automatic t_pin;
    wr_reg(8'h04, 32'h0000_0640);
    pdc <= 0;
    repeat (4) u_enc.step(1, 4);
    cyc(3);
    chk(pos, 16'h0001);
    chk(doe, 1);
    chk(dpo, 1);
    pdc <= 1;
    cyc(1);
    chk(doe, 0);
  endtask : t_pin
  task automatic t_filter;
    wr_reg(8'h00, 32'h0000_0080);
    // Let the empty filter fill before counting
    cyc(8);
    p = pulses;
    u_enc.glitch(0, 1);
    chk(pulses - p, 0);
    u_enc.glitch(0, 5);
    chk(pulses - p, 2);
    fork u_enc.glitch(2, 2); watch(18); join
    chk(hi, 0);
    wr_reg(8'h00, 32'h0000_00A0);
    p = pulses;
    u_enc.glitch(0, 5);
    chk(pulses - p, 0);
    u_enc.step(1, 16);
    cyc(2);
    chk(pulses - p, 1);
    wr_reg(8'h00, 32'h0000_0020);
    p = pulses;
    u_enc.glitch(0, 1);
    chk(pulses - p, 2);
    fork u_enc.glitch(2, 1); watch(18); join
    chk(hi, 1);
  endtask : t_filter
  task automatic t_lag;
    p = pulses;
    repeat (4) u_enc.step(0, 4);
    cyc(3);
    chk(pulses - p, 4);
    chk(pos, 16'hFFFE);
    chk(cd, 0);
  endtask : t_lag
  task automatic give_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    #(5000 * 100);
    errors++;
    give_verdict();
  end
  initial begin
    cyc(16);
    srst <= 0;
    cyc(1);
    t_reset();
    t_x4();
    t_rev();
    t_x2();
    t_swap();
    t_idle();
    t_pin();
    t_filter();
    t_lag();
    give_verdict();
  end
endmodule : tb_top
